// file: verilog/pt8_pkg.sv
`default_nettype none
package pt8_pkg;

    // ========================================================
    // widths
    localparam int PT8_CNT_W   = 8;
    localparam int PT8_PRE_W   = 7;
    localparam int PT8_SEL_W   = 3;
    localparam int PT8_POST_W  = 4;
    localparam int PT8_MODE_W  = 5;
    localparam int PT8_NSRC    = 8;

    // ========================================================
    // reset values
    localparam logic [7:0] PT8_COUNT_RST  = 8'h00;
    localparam logic [7:0] PT8_PERIOD_RST = 8'hff;
    localparam logic [6:0] PT8_PRE_RST    = 7'h00;
    localparam logic [3:0] PT8_POST_RST   = 4'h0;
    localparam logic [4:0] PT8_MODE_RST   = 5'h00;
    localparam logic [2:0] PT8_SRC_RST    = 3'h0;
    localparam logic [6:0] PT8_PRE_ONE    = 7'h01;

    // ========================================================
    // mode field layout: group in [4:3], option in [2:0]
    localparam int PT8_GRP_HI = 4;
    localparam int PT8_GRP_LO = 3;
    localparam int PT8_OPT_HI = 2;

    localparam logic [1:0] PT8_GRP_FREE = 2'h0;
    localparam logic [1:0] PT8_GRP_ONE  = 2'h1;
    localparam logic [1:0] PT8_GRP_MONO = 2'h2;

    localparam logic [2:0] PT8_OPT_0 = 3'h0;
    localparam logic [2:0] PT8_OPT_1 = 3'h1;
    localparam logic [2:0] PT8_OPT_2 = 3'h2;
    localparam logic [2:0] PT8_OPT_3 = 3'h3;
    localparam logic [2:0] PT8_OPT_4 = 3'h4;
    localparam logic [2:0] PT8_OPT_5 = 3'h5;
    localparam logic [2:0] PT8_OPT_6 = 3'h6;
    localparam logic [2:0] PT8_OPT_7 = 3'h7;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        PT8_PH_WAIT = 2'b01,
        PT8_PH_RUN  = 2'b10
    } pt8_phase_type;

    typedef struct packed {
        logic                  run;
        logic [PT8_SEL_W-1:0]  presc_sel;
        logic [PT8_POST_W-1:0] postscale_select;
    } pt8_ctrl_type;

    typedef struct packed {
        logic [PT8_CNT_W-1:0]  timer_count;
        logic [PT8_CNT_W-1:0]  period_value;
        logic [PT8_CNT_W-1:0]  period_buf;
        logic [PT8_PRE_W-1:0]  presc;
        logic [PT8_POST_W-1:0] post;
        pt8_ctrl_type          ctrl;
        logic [PT8_MODE_W-1:0] mode;
        logic [PT8_SEL_W-1:0]  src_sel;
        pt8_phase_type         phase;
        logic                  pulse;
        logic                  irq_flag;
    } pt8_state_type;

    typedef struct packed {
        logic cur;
        logic prev;
    } pt8_edge_state_type;

endpackage
`default_nettype wire

// file: verilog/pt8_edge.sv
`default_nettype none
module pt8_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic sample_en,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import pt8_pkg::*;

    pt8_edge_state_type st_r;
    pt8_edge_state_type st_nxt;

    // ========================================================
    // sample once per timer clock, keep the previous sample
    always_comb begin
        st_nxt = st_r;
        if (sample_en) begin
            st_nxt.prev = st_r.cur;
            st_nxt.cur  = din;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // edges stay visible for one timer clock
    assign level = st_r.cur;
    assign rise  = st_r.cur & ~st_r.prev;
    assign fall  = ~st_r.cur & st_r.prev;
endmodule
`default_nettype wire

// file: verilog/pt8_timer.sv
`default_nettype none
// Notes on behaviour
// RQ1 - count advances on each prescaler output tick
// RQ2 - match with buffer clears count, bumps postscaler
// RQ3 - reset clears count, period becomes all ones
// RQ4 - writes, reset, external reset clear scalers
// RQ5 - postscaler hit gives one timer clock pulse
// RQ6 - one-shot match clears run and stops
// RQ7 - one-shot makes nonzero postscale selections useless
// RQ8 - monostable keeps run set for retrigger
// RQ9 - period visible copy plus hidden compare buffer
// RQ10 - buffer reloads on writes, reset event, match
// RQ11 - source select and mode field steer trigger
// RQ12 - trigger edges spaced six timer clocks apart
// RQ13 - trigger levels held three timer clocks minimum
// RQ14 - debug freeze ignores external trigger events
// RQ15 - free gate modes: run, high, low
// RQ16 - free edge reset: both, rising, falling
// RQ17 - free level reset: low or high holds
// RQ18 - one-shot software or edge started
// RQ19 - one-shot edge start with hardware reset
// RQ20 - group 10 level one-shots, reserved codes
// RQ21 - monostable edge start, halts keeping run
// RQ22 - one-shot end clears run, edge rearms
// RQ23 - prescale 1 to 128, postscale 1 to 16
// RQ24 - postscaler hit sets flag, enable gates request
module pt8_timer (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          count_wr,
    input  wire logic [pt8_pkg::PT8_CNT_W-1:0] count_wdata,
    input  wire logic                          period_wr,
    input  wire logic [pt8_pkg::PT8_CNT_W-1:0] period_wdata,
    input  wire logic                          ctrl_wr,
    input  wire pt8_pkg::pt8_ctrl_type         ctrl_wdata,
    input  wire logic                          mode_wr,
    input  wire logic [pt8_pkg::PT8_MODE_W-1:0] mode_wdata,
    input  wire logic                          src_wr,
    input  wire logic [pt8_pkg::PT8_SEL_W-1:0] src_wdata,
    input  wire logic [pt8_pkg::PT8_NSRC-1:0]  ext_sources,
    input  wire logic                          debug_freeze,
    input  wire logic                          period_irq_enable,
    input  wire logic                          irq_clear,
    output logic [pt8_pkg::PT8_CNT_W-1:0]      timer_count,
    output logic [pt8_pkg::PT8_CNT_W-1:0]      period_value,
    output pt8_pkg::pt8_ctrl_type              ctrl_rdata,
    output logic [pt8_pkg::PT8_MODE_W-1:0]     mode_rdata,
    output logic [pt8_pkg::PT8_SEL_W-1:0]      src_rdata,
    output logic                               timer_tick,
    output logic                               postscaled_pulse,
    output logic                               irq_flag,
    output logic                               irq_req
);
    import pt8_pkg::*;

    pt8_state_type st_r;
    pt8_state_type st_nxt;

    logic                  ext_trigger_signal;
    logic                  ers_lvl;
    logic                  ers_rise_raw;
    logic                  ers_fall_raw;
    logic                  ers_rise;
    logic                  ers_fall;
    logic [PT8_PRE_W-1:0]  presc_lim;
    logic [1:0]            grp;
    logic [2:0]            opt;

    // ========================================================
    // prescaler
    // ratio is 2**presc_sel, 1:1 up to 1:128
    assign presc_lim = 7'((8'h01 << st_r.ctrl.presc_sel) - 8'h01); // [RQ23]
    assign timer_tick = (st_r.presc == presc_lim);

    // ========================================================
    // external trigger selection and sampling
    assign ext_trigger_signal = ext_sources[st_r.src_sel]; // [RQ11]

    // sampling stops while frozen, so the last sampled edge is held
    pt8_edge u_edge (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .sample_en (timer_tick & ~debug_freeze), // [RQ14]
        .din       (ext_trigger_signal),
        .level     (ers_lvl),
        .rise      (ers_rise_raw),
        .fall      (ers_fall_raw)
    );

    // stale edges are masked during freeze
    assign ers_rise = ers_rise_raw & ~debug_freeze; // [RQ14]
    assign ers_fall = ers_fall_raw & ~debug_freeze; // [RQ14]

    assign grp = st_r.mode[PT8_GRP_HI:PT8_GRP_LO];
    assign opt = st_r.mode[PT8_OPT_HI:0];

    // ========================================================
    // next state
    always_comb begin
        logic en_cnt;
        logic do_rst;
        logic start_evt;
        logic one_shot;
        logic hit;
        logic post_hit;
        logic clr_scal;
        en_cnt    = 1'b0;
        do_rst    = 1'b0;
        start_evt = 1'b0;
        one_shot  = 1'b0;
        hit       = 1'b0;
        post_hit  = 1'b0;
        clr_scal  = 1'b0;
        st_nxt    = st_r;

        // prescaler runs every enabled clock
        st_nxt.presc = timer_tick ? PT8_PRE_RST
                                  : 7'(st_r.presc + PT8_PRE_ONE);

        // mode decode
        case (grp)
            PT8_GRP_FREE: begin
                en_cnt = st_r.ctrl.run; // [RQ15]
                case (opt)
                    PT8_OPT_1: en_cnt = st_r.ctrl.run & ers_lvl;  // [RQ15]
                    PT8_OPT_2: en_cnt = st_r.ctrl.run & ~ers_lvl; // [RQ15]
                    PT8_OPT_3: do_rst = ers_rise | ers_fall; // [RQ16]
                    PT8_OPT_4: do_rst = ers_rise;            // [RQ16]
                    PT8_OPT_5: do_rst = ers_fall;            // [RQ16]
                    PT8_OPT_6: do_rst = ~ers_lvl;            // [RQ17]
                    PT8_OPT_7: do_rst = ers_lvl;             // [RQ17]
                    default:   do_rst = 1'b0;
                endcase
            end
            PT8_GRP_ONE: begin
                one_shot = 1'b1; // [RQ6]
                en_cnt   = st_r.ctrl.run & (st_r.phase == PT8_PH_RUN);
                case (opt)
                    PT8_OPT_0: start_evt = 1'b1;                // [RQ18]
                    PT8_OPT_1: start_evt = ers_rise;            // [RQ18]
                    PT8_OPT_2: start_evt = ers_fall;            // [RQ18]
                    PT8_OPT_3: start_evt = ers_rise | ers_fall; // [RQ18]
                    PT8_OPT_4: begin
                        start_evt = ers_rise; // [RQ19]
                        do_rst    = ers_rise & en_cnt; // [RQ19]
                    end
                    PT8_OPT_5: begin
                        start_evt = ers_fall; // [RQ19]
                        do_rst    = ers_fall & en_cnt; // [RQ19]
                    end
                    PT8_OPT_6: begin
                        start_evt = ers_rise; // [RQ19]
                        do_rst    = ~ers_lvl & en_cnt; // [RQ19]
                    end
                    PT8_OPT_7: begin
                        start_evt = ers_fall; // [RQ19]
                        do_rst    = ers_lvl & en_cnt; // [RQ19]
                    end
                    default: start_evt = 1'b0;
                endcase
            end
            PT8_GRP_MONO: begin
                en_cnt = st_r.ctrl.run & (st_r.phase == PT8_PH_RUN);
                case (opt)
                    PT8_OPT_1: start_evt = ers_rise;            // [RQ21]
                    PT8_OPT_2: start_evt = ers_fall;            // [RQ21]
                    PT8_OPT_3: start_evt = ers_rise | ers_fall; // [RQ21]
                    PT8_OPT_6: begin
                        one_shot  = 1'b1;     // [RQ20]
                        start_evt = ers_lvl;  // [RQ20]
                        do_rst    = ~ers_lvl; // [RQ20]
                    end
                    PT8_OPT_7: begin
                        one_shot  = 1'b1;     // [RQ20]
                        start_evt = ~ers_lvl; // [RQ20]
                        do_rst    = ers_lvl;  // [RQ20]
                    end
                    default: en_cnt = 1'b0; // reserved: frozen [RQ20]
                endcase
            end
            default: begin
                en_cnt = 1'b0; // reserved group holds still [RQ20]
            end
        endcase

        // external signal is ignored while run is off
        do_rst = do_rst & st_r.ctrl.run;

        // count and control writes hold off timer events; a standing pulse still ends
        st_nxt.pulse = st_r.pulse & ~timer_tick; // [RQ5]
        if (timer_tick && !count_wr && !ctrl_wr) begin
            // arm: qualifying start seen with run set
            if (st_r.ctrl.run && start_evt &&
                st_r.phase == PT8_PH_WAIT) begin
                st_nxt.phase = PT8_PH_RUN;
            end

            // count and compare against the hidden buffer
            if (en_cnt) begin
                hit = (st_r.timer_count == st_r.period_buf); // [RQ2]
                if (hit) begin
                    st_nxt.timer_count = PT8_COUNT_RST;  // [RQ2]
                    st_nxt.period_buf  = st_r.period_value; // [RQ10]
                    post_hit = (st_r.post ==
                                st_r.ctrl.postscale_select); // [RQ5]
                    st_nxt.post = post_hit ? PT8_POST_RST
                        : 4'(st_r.post + 4'h1); // [RQ2] [RQ5]
                    if (grp != PT8_GRP_FREE) begin
                        // halts at zero, needs a fresh start [RQ22]
                        st_nxt.phase = PT8_PH_WAIT; // [RQ21]
                        st_nxt.post  = PT8_POST_RST; // [RQ7]
                    end
                    if (one_shot) begin
                        st_nxt.ctrl.run = 1'b0; // [RQ6] [RQ22]
                    end
                end else begin
                    st_nxt.timer_count =
                        8'(st_r.timer_count + 8'h01); // [RQ1]
                end
            end

            // external reset event
            if (do_rst) begin
                st_nxt.timer_count = PT8_COUNT_RST;     // [RQ16]
                st_nxt.period_buf  = st_r.period_value; // [RQ10]
                clr_scal = 1'b1; // [RQ4]
            end

            // postscaled output is one timer clock wide
            st_nxt.pulse = post_hit & ~do_rst; // [RQ5]
        end

        // monostable keeps run set [RQ8]
        if (!st_r.ctrl.run) begin
            st_nxt.phase = PT8_PH_WAIT; // rearm needs a start event with run set [RQ22]
        end

        // software writes take priority over timer events
        if (count_wr) begin
            st_nxt.timer_count = count_wdata;       // [RQ3]
            st_nxt.period_buf  = st_r.period_value; // [RQ10]
            clr_scal = 1'b1; // [RQ4]
        end
        if (period_wr) begin
            st_nxt.period_value = period_wdata; // visible copy [RQ9]
        end
        if (ctrl_wr) begin
            st_nxt.ctrl       = ctrl_wdata;
            st_nxt.period_buf = st_r.period_value; // [RQ10]
            clr_scal = 1'b1; // count kept [RQ4]
            if (!ctrl_wdata.run) begin
                st_nxt.phase = PT8_PH_WAIT;
            end
        end
        if (mode_wr) begin
            st_nxt.mode = mode_wdata; // [RQ11]
        end
        if (src_wr) begin
            st_nxt.src_sel = src_wdata; // [RQ11]
        end

        if (clr_scal) begin
            st_nxt.presc = PT8_PRE_RST; // [RQ4]
            st_nxt.post  = PT8_POST_RST; // [RQ4]
        end

        // interrupt flag: set wins over clear
        if (irq_clear) begin
            st_nxt.irq_flag = 1'b0;
        end
        if (timer_tick && st_nxt.pulse) begin
            st_nxt.irq_flag = 1'b1; // [RQ24]
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r              <= '0;
            st_r.timer_count  <= PT8_COUNT_RST;  // [RQ3]
            st_r.period_value <= PT8_PERIOD_RST; // [RQ3]
            st_r.period_buf   <= PT8_PERIOD_RST; // [RQ3]
            st_r.presc        <= PT8_PRE_RST;    // [RQ4]
            st_r.post         <= PT8_POST_RST;   // [RQ4]
            st_r.mode         <= PT8_MODE_RST;
            st_r.src_sel      <= PT8_SRC_RST;
            st_r.phase        <= PT8_PH_WAIT;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // outputs
    assign timer_count      = st_r.timer_count;
    assign period_value     = st_r.period_value;
    assign ctrl_rdata       = st_r.ctrl;
    assign mode_rdata       = st_r.mode;
    assign src_rdata        = st_r.src_sel;
    assign postscaled_pulse = st_r.pulse;
    assign irq_flag         = st_r.irq_flag;
    assign irq_req          = st_r.irq_flag & period_irq_enable; // [RQ24]

endmodule
`default_nettype wire

// file: verif/pt8_src_model.sv
`default_nettype none
// ========================================================
// far side: trigger source lines ahead of the select mux
module pt8_src_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] want,
    output logic      [7:0] ext_sources
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] gap_r;

    // follow the request, changes at least six clocks apart
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_sources <= 8'h00;
            gap_r <= 4'h0;
        end else if (want != ext_sources && gap_r > 4'h4) begin
            ext_sources <= want;
            gap_r <= 4'h0;
        end else if (gap_r != 4'hf) begin
            gap_r <= gap_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: verif/pt8_timer_chk.sv
`default_nettype none
// ========================================================
// port checker for the period timer
module pt8_timer_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire logic                  count_wr,
    input wire logic [7:0]            count_wdata,
    input wire logic                  ctrl_wr,
    input wire logic [7:0]            timer_count,
    input wire logic [7:0]            period_value,
    input wire pt8_pkg::pt8_ctrl_type ctrl_rdata,
    input wire logic [4:0]            mode_rdata,
    input wire logic                  timer_tick,
    input wire logic                  postscaled_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    import pt8_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_rst_val;
        $fell(rst) |-> timer_count == 8'h00 && period_value == 8'hff;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("bad values after reset");

    property p_cnt_load;
        ce && count_wr |=> timer_count == $past(count_wdata);
    endproperty
    a_cnt_load: assert property (p_cnt_load)
        else $error("count write not taken");

    property p_step;
        ce && timer_tick && ctrl_rdata.run && mode_rdata == 5'h00
            && !count_wr && !ctrl_wr
            |=> timer_count == $past(timer_count) + 8'h01
            || timer_count == 8'h00;
    endproperty
    a_step: assert property (p_step)
        else $error("count did not step");

    property p_stop;
        !ctrl_rdata.run && mode_rdata == 5'h00 && !count_wr
            |=> $stable(timer_count);
    endproperty
    a_stop: assert property (p_stop)
        else $error("count moved while stopped");

    property p_pulse_src;
        $rose(postscaled_pulse) |-> $past(timer_tick)
            && timer_count == 8'h00;
    endproperty
    a_pulse_src: assert property (p_pulse_src)
        else $error("pulse without period match");

    property p_pulse_one;
        postscaled_pulse && timer_tick && !count_wr && !ctrl_wr
            && timer_count != period_value |=> !postscaled_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("pulse wider than one tick");

    property p_os_end;
        $rose(postscaled_pulse) && mode_rdata[4:3] == 2'h1
            |-> !ctrl_rdata.run;
    endproperty
    a_os_end: assert property (p_os_end)
        else $error("one-shot kept running");

    property p_mono_keep;
        $rose(postscaled_pulse) && mode_rdata == 5'h11
            |-> ctrl_rdata.run;
    endproperty
    a_mono_keep: assert property (p_mono_keep)
        else $error("monostable dropped run");

    c_pulse: cover property ($rose(postscaled_pulse));
    c_os: cover property ($fell(ctrl_rdata.run));
    c_mono: cover property (postscaled_pulse && mode_rdata == 5'h11);
endmodule

bind pt8_timer pt8_timer_chk chk_u (
    .clk, .rst, .ce, .count_wr, .count_wdata, .ctrl_wr, .timer_count,
    .period_value, .ctrl_rdata, .mode_rdata, .timer_tick,
    .postscaled_pulse
);
`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pt8_pkg::*;

    // ========================================================
    // stimulus and observed signals
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, irq_clear = 1'h0;
    logic count_wr = 1'h0, period_wr = 1'h0, ctrl_wr = 1'h0;
    logic mode_wr = 1'h0, src_wr = 1'h0, debug_freeze = 1'h0;
    logic period_irq_enable = 1'h0;
    logic [7:0] count_wdata = 8'h00, period_wdata = 8'h00;
    logic [7:0] want = 8'h00, ext_sources, timer_count, period_value;
    pt8_ctrl_type ctrl_wdata = 8'h00, ctrl_rdata;
    logic [4:0] mode_wdata = 5'h00, mode_rdata;
    logic [2:0] src_wdata = 3'h0, src_rdata;
    logic timer_tick, postscaled_pulse, irq_flag, irq_req;
    int fail_count = 0, checked = 0, seed = 32'h7400;
    logic [7:0] cnt, vis, pbuf, a, b;
    logic [6:0] pc;
    logic [3:0] post;
    logic pl, irqf, rn, armed, pok, tk;
    logic [4:0] opt_tab [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                5'h05, 5'h06, 5'h07, 5'h04};
    logic init_tab [8] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};

    pt8_timer dut_u (.clk, .rst, .ce, .count_wr, .count_wdata, .period_wr,
        .period_wdata, .ctrl_wr, .ctrl_wdata, .mode_wr, .mode_wdata,
        .src_wr, .src_wdata, .ext_sources, .debug_freeze,
        .period_irq_enable, .irq_clear, .timer_count, .period_value,
        .ctrl_rdata, .mode_rdata, .src_rdata, .timer_tick,
        .postscaled_pulse, .irq_flag, .irq_req);
    pt8_src_model src_u (.clk, .rst, .want, .ext_sources);

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // ========================================================
    // helpers
    task automatic ck(input bit c, input string m);
        checked++;
        if (!c) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one strobe: 0 count 1 period 2 ctrl 3 mode 4 src 5 irq clear
    task automatic wr(input int i, input logic [7:0] d);
        @(posedge clk);
        count_wdata <= d;
        period_wdata <= d;
        ctrl_wdata <= pt8_ctrl_type'(d);
        mode_wdata <= d[4:0];
        src_wdata <= d[2:0];
        {count_wr, period_wr, ctrl_wr} <= {i == 0, i == 1, i == 2};
        {mode_wr, src_wr, irq_clear} <= {i == 3, i == 4, i == 5};
        @(posedge clk);
        {count_wr, period_wr, ctrl_wr, mode_wr, src_wr, irq_clear} <= 6'h00;
    endtask

    // reference model run in free or one-shot mode, random writes only in free mode
    task automatic run_model(input bit os, input int k, s, p, n);
        int r;
        logic st;
        wr(2, {1'h0, k[2:0], s[3:0]});
        wr(5, 8'h00);
        wr(3, os ? 8'h08 : 8'h00);
        wr(1, p[7:0]);
        wr(0, 8'h00);
        wr(2, {1'h1, k[2:0], s[3:0]});
        {cnt, vis, pbuf, pc, post} = {8'h00, p[7:0], p[7:0], 11'h000};
        {irqf, rn, armed, pok, pl} = {1'h0, 1'h1, !os, 2'h0};
        for (int j = n; j > 0; j--) begin
            @(negedge clk);
            tk = (pc == (7'h01 << k) - 7'h01);
            ck(timer_tick === tk, "tick");
            ck(timer_count === cnt, "count");
            ck(period_value === vis, "period");
            ck(!pok || postscaled_pulse === pl, "pulse");
            ck(irq_flag === irqf, "flag");
            ck(irq_req === (irqf & period_irq_enable), "request");
            ck(ctrl_rdata.run === rn, "run bit");
            @(posedge clk);
            st = 1'h0;
            if (count_wr || ctrl_wr) begin
                cnt = count_wr ? count_wdata : cnt;
                {pc, post, pbuf, pok} = {11'h000, vis, 1'h0};
            end else if (tk) begin
                {pc, pok, pl} = {7'h00, 2'h2};
                if (rn && !armed) begin
                    armed = 1'h1;
                end else if (rn && cnt == pbuf) begin
                    {cnt, pbuf, st} = {8'h00, vis, post == s[3:0]};
                    pl = st;
                    post = (st || os) ? 4'h0 : post + 4'h1;
                    rn = !os;
                    armed = !os;
                end else if (rn) begin
                    cnt = cnt + 8'h01;
                end
            end else begin
                pc = pc + 7'h01;
            end
            irqf = st || (irqf && !irq_clear);
            vis = period_wr ? period_wdata : vis;
            r = (os || j == 1) ? 9 : $unsigned($random(seed)) % 32;
            {count_wr, period_wr, ctrl_wr} <= {r == 0, r == 1, r == 2};
            irq_clear <= (r == 3);
            count_wdata <= 8'($unsigned($random(seed)) % 12 + 1);
            period_wdata <= 8'($unsigned($random(seed)) % 12 + 1);
            period_irq_enable <= r[4];
        end
    endtask

    // ========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        ck(timer_count === 8'h00 && period_value === 8'hff, "reset");
        ck({ctrl_rdata, mode_rdata, src_rdata, postscaled_pulse, irq_flag}
            === 18'h00000, "reset");
        for (int i = 0; i < 5; i++) begin
            a = 8'($unsigned($random(seed)) % 12 + 1);
            b = 8'($unsigned($random(seed)) % 4);
            run_model(0, i % 3, b, a, 2 * (a + 1) * (b + 1) * 4 + 20);
        end
        for (int i = 0; i < 3; i++) begin
            run_model(1, 0, i, 3 + i, 2 * i + 14);
        end
        wr(1, 8'hff);
        wr(2, 8'h80);
        for (int i = 0; i < 8; i++) begin
            b = 8'($unsigned($random(seed)) % 8);
            @(posedge clk);
            want <= init_tab[i] ? 8'h01 << b : ~(8'h01 << b);
            debug_freeze <= (i == 7);
            wr(4, b);
            wr(3, opt_tab[i]);
            wr(0, 8'h00);
            repeat (11) @(posedge clk);
            @(negedge clk);
            a = timer_count;
            ck(mode_rdata === opt_tab[i] && src_rdata === b[2:0], "sel");
            @(posedge clk);
            want <= ~want;
            repeat (5) @(posedge clk);
            @(negedge clk);
            b = timer_count;
            if (i < 2) begin
                ck(a <= 8'h02 && b > a, "gate");
            end else if (i == 7) begin
                ck(b > a, "freeze");
            end else begin
                ck(a >= 8'h08 && b < a, "ext reset");
            end
        end
        @(posedge clk);
        debug_freeze <= 1'h0;
        want <= 8'h00;
        wr(1, 8'h05);
        wr(3, 8'h11);
        wr(2, 8'h00);
        wr(0, 8'h00);
        wr(2, 8'h80);
        repeat (8) @(posedge clk);
        @(negedge clk);
        ck(timer_count === 8'h00, "mono idle");
        @(posedge clk);
        want <= 8'hff;
        repeat (16) @(posedge clk);
        @(negedge clk);
        ck(timer_count === 8'h00 && ctrl_rdata.run === 1'h1, "mono");
        @(posedge clk);
        want <= 8'h00;
        repeat (8) @(posedge clk);
        want <= 8'hff;
        repeat (5) @(posedge clk);
        @(negedge clk);
        ck(timer_count !== 8'h00, "retrigger");
        wr(3, 8'h18);
        wr(0, 8'h03);
        repeat (6) @(posedge clk);
        @(negedge clk);
        ck(timer_count === 8'h03, "reserved");
        @(posedge clk);
        ce <= 1'h0;
        wr(0, 8'h07);
        @(negedge clk);
        ck(timer_count === 8'h03, "clock enable");
        print_verdict();
    end
endmodule
`default_nettype wire
